// >>> frs_sequencer.sv
// fault response and soft-start sequencer
`timescale 1ns/1ps
`include "frs_params.svh"
module frs_sequencer (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic threshold_enable_input_in,
    input wire logic logic_supply_por_ok_in,
    input wire logic driver_supply_por_ok_in,
    input wire logic open_sense_cmp_in,
    input wire logic overcurrent_cmp_in,
    input wire logic [7:0] ss_steps_in,
    input wire logic [`FRS_NUM_PHASES-1:0] pwm_request_in,
    output logic [`FRS_NUM_PHASES-1:0] pwm_out,
    output logic [`FRS_NUM_PHASES-1:0] pwm_oe_n_out,
    output logic [7:0] ref_step_out,
    output logic prepor_clamp_arm_out,
    output logic power_good_flag_out,
    output frs_pkg::frs_state_e state_out
);
    import frs_pkg::*;

    localparam int NPH = `FRS_NUM_PHASES;
    localparam frs_count_t OC_WAIT_LAST = 13'(`FRS_OC_WAIT_CYCLES - 1);
    localparam frs_count_t SS_DELAY_LAST = 13'(`FRS_SS_DELAY_CYCLES - 1);
    localparam frs_count_t SS_STEP_LAST = 13'(`FRS_SS_STEP_CYCLES - 1);

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    logic [4:0] raw_inputs;
    logic [4:0] sync_inputs;
    logic enable_s;
    logic vcc_ok_s;
    logic driver_supply_ok_s;
    logic open_sense_s;
    logic oc_s;

    // every comparator and status pin is asynchronous to clk_in
    assign raw_inputs = {overcurrent_cmp_in, open_sense_cmp_in, driver_supply_por_ok_in,
                         logic_supply_por_ok_in, threshold_enable_input_in};

    frs_sync #(.W(5)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(raw_inputs),
        .q_out(sync_inputs)
    );

    assign enable_s = sync_inputs[0];
    assign vcc_ok_s = sync_inputs[1];
    assign driver_supply_ok_s = sync_inputs[2];
    assign open_sense_s = sync_inputs[3];
    assign oc_s = sync_inputs[4];

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    frs_state_e state_reg;
    frs_state_e state_next;
    frs_count_t count_reg;
    frs_count_t count_next;
    logic [7:0] step_reg;
    logic [7:0] step_next;
    logic power_good_flag_reg;
    logic power_good_flag_next;
    logic go_ok;

    // all start conditions; an open sense line also holds shutdown
    assign go_ok = enable_s && vcc_ok_s && driver_supply_ok_s && !open_sense_s;

    // next-state logic
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        step_next = step_reg;
        power_good_flag_next = power_good_flag_reg;
        case (state_reg)
            FRS_OFF: begin
                count_next = '0;
                step_next = '0;
                power_good_flag_next = 1'b0;
                if (go_ok) begin
                    state_next = FRS_SS_DELAY;
                end
            end
            FRS_SS_DELAY: begin
                if (count_reg == SS_DELAY_LAST) begin
                    count_next = '0;
                    state_next = FRS_SS_RAMP;
                end else begin
                    count_next = count_reg + 13'h0001;
                end
            end
            FRS_SS_RAMP: begin
                if (count_reg == SS_STEP_LAST) begin
                    count_next = '0;
                    step_next = step_reg + 8'h01;
                    if (step_reg + 8'h01 >= ss_steps_in) begin
                        state_next = FRS_RUN;
                        power_good_flag_next = 1'b1;
                    end
                end else begin
                    count_next = count_reg + 13'h0001;
                end
            end
            FRS_RUN: begin
                count_next = '0;
            end
            FRS_OC_WAIT: begin
                // unlimited retries: wait is re-entered on every trip
                if (count_reg == OC_WAIT_LAST) begin
                    count_next = '0;
                    step_next = '0;
                    state_next = FRS_SS_DELAY;
                end else begin
                    count_next = count_reg + 13'h0001;
                end
            end
            default: begin
                state_next = FRS_OFF;
                count_next = '0;
            end
        endcase
        // overcurrent overrides any active phase
        if (oc_s && state_reg != FRS_OFF && state_reg != FRS_OC_WAIT) begin
            state_next = FRS_OC_WAIT;
            count_next = '0;
            power_good_flag_next = 1'b0;
        end
        // disable, POR loss or open sense forces shutdown, clearing the wait
        if (!go_ok) begin
            state_next = FRS_OFF;
            count_next = '0;
            step_next = '0;
            power_good_flag_next = 1'b0;
        end
    end

    // registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= FRS_OFF;
            count_reg <= '0;
            step_reg <= '0;
            power_good_flag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            step_reg <= step_next;
            power_good_flag_reg <= power_good_flag_next;
        end
    end

    // ------------------------------------------------------------
    // gate and flag outputs
    // ------------------------------------------------------------
    logic [NPH-1:0] pwm_reg;
    logic [NPH-1:0] pwm_next;
    logic [NPH-1:0] oe_n_reg;
    logic [NPH-1:0] oe_n_next;
    logic drive_ok;
    logic clamp_reg;
    logic clamp_next;

    // gates only switch while the soft-start ramp or run is active; the
    // trip is taken from state_next so the gates drop on the same edge
    assign drive_ok = (state_next == FRS_SS_RAMP) || (state_next == FRS_RUN);

    genvar g;
    generate
        for (g = 0; g < NPH; g++) begin : g_phase
            always_comb begin
                pwm_next[g] = drive_ok & pwm_request_in[g];
                oe_n_next[g] = !drive_ok;
            end
        end
    endgenerate

    // clamp path re-armed whenever either supply is below POR
    always_comb begin
        clamp_next = !(vcc_ok_s && driver_supply_ok_s);
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwm_reg <= '0;
            oe_n_reg <= '1;
            clamp_reg <= 1'b1;
        end else begin
            pwm_reg <= pwm_next;
            oe_n_reg <= oe_n_next;
            clamp_reg <= clamp_next;
        end
    end

    assign pwm_out = pwm_reg;
    assign pwm_oe_n_out = oe_n_reg;
    assign ref_step_out = step_reg;
    assign prepor_clamp_arm_out = clamp_reg;
    assign power_good_flag_out = power_good_flag_reg;
    assign state_out = state_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_oc_gates_off: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == FRS_OC_WAIT) |-> (pwm_oe_n_out == '1 && pwm_out == '0))
        else $error("gates active during overcurrent wait");
    a_oc_enter: assert property (@(posedge clk_in) disable iff (rst_in)
        (oc_s && go_ok && (state_reg == FRS_RUN)) |=> (state_reg == FRS_OC_WAIT))
        else $error("overcurrent not entered");
    a_oc_wait_len: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == FRS_OC_WAIT && count_reg < OC_WAIT_LAST && go_ok) |=> (state_reg == FRS_OC_WAIT))
        else $error("overcurrent wait ended early");
    a_oc_retry: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == FRS_OC_WAIT && count_reg == OC_WAIT_LAST && go_ok) |=> (state_reg == FRS_SS_DELAY))
        else $error("no retry after wait");
    a_open_shut: assert property (@(posedge clk_in) disable iff (rst_in)
        open_sense_s |=> (state_reg == FRS_OFF))
        else $error("open sense did not shut down");
    a_restart_ss: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == FRS_OFF && go_ok) |=> (state_reg == FRS_SS_DELAY && count_reg == '0))
        else $error("restart not at soft-start beginning");
    // a trip or shutdown may cut the delay short; only a quiet early exit is an error
    a_ss_delay: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == FRS_SS_DELAY && count_reg < SS_DELAY_LAST && go_ok && !oc_s) |=> (state_reg == FRS_SS_DELAY))
        else $error("soft-start delay too short");
    a_power_good_flag_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == FRS_OC_WAIT) |-> !power_good_flag_out)
        else $error("power good high in overcurrent");
    a_off_hiz: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg == FRS_OFF) |-> (pwm_oe_n_out == '1))
        else $error("pwm driven in shutdown");
    a_clamp_arm: assert property (@(posedge clk_in) disable iff (rst_in)
        (!vcc_ok_s || !driver_supply_ok_s) |=> prepor_clamp_arm_out)
        else $error("clamp not re-armed");
    a_wait_clear: assert property (@(posedge clk_in) disable iff (rst_in)
        !enable_s |=> (count_reg == '0))
        else $error("wait counter not cleared");

    c_oc_trip: cover property (@(posedge clk_in) disable iff (rst_in)
        state_reg == FRS_RUN ##1 state_reg == FRS_OC_WAIT);
    c_retry: cover property (@(posedge clk_in) disable iff (rst_in)
        state_reg == FRS_OC_WAIT ##1 state_reg == FRS_SS_DELAY);
    c_run: cover property (@(posedge clk_in) disable iff (rst_in) $rose(power_good_flag_out));
endmodule : frs_sequencer

// >>> frs_params.svh
// constants for the fault retry sequencer
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH
`define FRS_OC_WAIT_CYCLES 4096
`define FRS_SS_DELAY_CYCLES 16
`define FRS_SS_STEP_CYCLES 16
`define FRS_SS_STEP_UV 12500
`define FRS_SS_STEPS_DEFAULT 128
`define FRS_NUM_PHASES 2
`endif

// >>> frs_pkg.sv
// types for the fault retry sequencer
package frs_pkg;
    typedef enum logic [4:0] {
        FRS_OFF = 5'b0_0001,
        FRS_SS_DELAY = 5'b0_0010,
        FRS_SS_RAMP = 5'b0_0100,
        FRS_RUN = 5'b0_1000,
        FRS_OC_WAIT = 5'b1_0000
    } frs_state_e;
    typedef logic [12:0] frs_count_t;
endpackage : frs_pkg

// >>> frs_sync.sv
// two flip-flop synchroniser for a vector of level inputs
`timescale 1ns/1ps
module frs_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    // next values: first stage feeds only the second
    always_comb begin
        meta_next = d_in;
        q_next = meta_reg;
    end

    // registers
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q_out = q_reg;
endmodule : frs_sync

// >>> frs_partner.sv
// stand-in for the modulator and the gate drivers beside the sequencer
`timescale 1ns/1ps
module frs_partner (
    input wire logic clk_in,
    input wire logic [1:0] pwm_in,
    input wire logic [1:0] pwm_oe_n_in,
    output logic [1:0] pwm_request_out,
    output logic [1:0] gate_level_out
);
    // ----------------------------------------
    // modulator and driver model
    // ----------------------------------------
    logic [1:0] req_reg = 2'h1;
    // phases in antiphase, toggling every cycle just after the edge
    always @(posedge clk_in) begin
        req_reg <= #1 ~req_reg;
    end
    assign pwm_request_out = req_reg;
    // a released pin shows a moving pattern, never a held value
    assign gate_level_out = (pwm_in & ~pwm_oe_n_in) | (~pwm_request_out & pwm_oe_n_in);
endmodule : frs_partner

// >>> tb_top.sv
// self-checking testbench for the fault retry sequencer
`timescale 1ns/1ps
module tb_top;
    import frs_pkg::*;
    logic clk_in = 0, rst_in = 1, en = 0, lpor = 1, dpor = 1, osense = 0, oc = 0;
    logic [1:0] req, pwm, oe_n, gate;
    logic [7:0] ref_step;
    logic clamp, power_good_flag, r;
    frs_state_e state_out;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    // ----------------------------------------
    // clock, instances, hang limit
    // ----------------------------------------
    always #12.5 clk_in = ~clk_in;
    frs_sequencer u_frs_sequencer (.clk_in(clk_in), .rst_in(rst_in), .threshold_enable_input_in(en),
        .logic_supply_por_ok_in(lpor), .driver_supply_por_ok_in(dpor), .open_sense_cmp_in(osense),
        .overcurrent_cmp_in(oc), .ss_steps_in(8'h02), .pwm_request_in(req), .pwm_out(pwm),
        .pwm_oe_n_out(oe_n), .ref_step_out(ref_step), .prepor_clamp_arm_out(clamp),
        .power_good_flag_out(power_good_flag), .state_out(state_out));
    frs_partner u_frs_partner (.clk_in(clk_in), .pwm_in(pwm), .pwm_oe_n_in(oe_n),
        .pwm_request_out(req), .gate_level_out(gate));
    // about 13k cycles expected; the margin covers the bounded waits
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // drive and sample 3 ns after the edge, away from the sampling instant
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #3;
    endtask : step
    task automatic chk_st(input frs_state_e exp);
        comparisons++;
        if (state_out !== exp) begin
            n_mismatch++;
            $display("FAIL %0t state %b expected %b", $time, state_out, exp);
        end
    endtask : chk_st
    task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk_v
    task automatic wait_st(input frs_state_e exp, input int lim);
        for (int i = 0; i < lim && state_out !== exp; i++) step(1);
        chk_st(exp);
    endtask : wait_st
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_start();
        // supplies not yet through the synchroniser: clamp still armed from reset
        chk_v(clamp, 1);
        chk_v(oe_n, 2'h3);
        en = 1;
        step(3);
        chk_st(FRS_SS_DELAY);
        chk_v(oe_n, 2'h3);
        chk_v(clamp, 0);
        step(15);
        chk_st(FRS_SS_DELAY);
        step(1);
        chk_st(FRS_SS_RAMP);
        chk_v(power_good_flag, 0);
        wait_st(FRS_RUN, 100);
        chk_v(ref_step, 8'h02);
        chk_v(power_good_flag, 1);
        r = req[0];
        step(1);
        chk_v(pwm, {~r, r});
        $display("test start done");
    endtask : t_start
    // trip in run, exact wait, retrip from the delay phase
    task automatic t_oc();
        oc = 1;
        step(3);
        chk_st(FRS_OC_WAIT);
        chk_v({oe_n, pwm}, 4'hC);
        chk_v(power_good_flag, 0);
        oc = 0;
        step(4095);
        chk_st(FRS_OC_WAIT);
        step(1);
        chk_st(FRS_SS_DELAY);
        oc = 1;
        step(3);
        chk_st(FRS_OC_WAIT);
        oc = 0;
        step(4096);
        chk_st(FRS_SS_DELAY);
        wait_st(FRS_RUN, 100);
        $display("test overcurrent done");
    endtask : t_oc
    // disable during the wait: no restart when the count runs out
    task automatic t_disable();
        oc = 1;
        step(3);
        chk_st(FRS_OC_WAIT);
        oc = 0;
        en = 0;
        step(3);
        chk_st(FRS_OFF);
        step(4096);
        chk_st(FRS_OFF);
        en = 1;
        step(3);
        chk_st(FRS_SS_DELAY);
        wait_st(FRS_RUN, 100);
        $display("test disable done");
    endtask : t_disable
    task automatic t_open();
        osense = 1;
        step(3);
        chk_st(FRS_OFF);
        chk_v({oe_n, power_good_flag}, 3'h6);
        osense = 0;
        step(3);
        chk_st(FRS_SS_DELAY);
        chk_v(ref_step, 0);
        wait_st(FRS_RUN, 100);
        $display("test open sense done");
    endtask : t_open
    // each supply dropping below its threshold re-arms the clamp
    task automatic t_supply();
        dpor = 0;
        step(3);
        chk_v(clamp, 1);
        chk_st(FRS_OFF);
        dpor = 1;
        step(3);
        chk_v(clamp, 0);
        lpor = 0;
        step(3);
        chk_v(clamp, 1);
        lpor = 1;
        step(3);
        chk_v(clamp, 0);
        chk_st(FRS_SS_DELAY);
        $display("test supply done");
    endtask : t_supply
    initial begin
        step(6);
        rst_in = 0;
        t_start();
        t_oc();
        t_disable();
        t_open();
        t_supply();
        end_of_test();
    end
endmodule : tb_top
